// >>> core/iphri_defs.svh
// offsets, field positions and timing counts of the host register interface
// assumes inclusion by bare name from core files
`ifndef IPHRI_DEFS_SVH
`define IPHRI_DEFS_SVH

// =====================================================================
// register offsets (byte ports)
`define IPHRI_OFS_RELOC_LOW   8'h80
`define IPHRI_OFS_RELOC_HIGH  8'h81
`define IPHRI_OFS_PTR_LOW     8'h82
`define IPHRI_OFS_PTR_HIGH    8'h83
`define IPHRI_OFS_STATE_CMD   8'h84

// =====================================================================
// controller_state bits
`define IPHRI_ST_HARD_ERR     7
`define IPHRI_ST_DOUBLE_ERR   6
`define IPHRI_ST_ADDR_MODE    3
`define IPHRI_ST_IRQ_PEND     2
`define IPHRI_ST_ATTN_ACK     1
`define IPHRI_ST_READY        0

// =====================================================================
// controller_command bits
`define IPHRI_CMD_CLR_ERR     7
`define IPHRI_CMD_IRQ_ACK     6
`define IPHRI_CMD_RESET       5
`define IPHRI_CMD_IRQ_EOC     4
`define IPHRI_CMD_BYTE_WORD   3
`define IPHRI_CMD_CLR_IRQ     2
`define IPHRI_CMD_ATTN_REQ    1
`define IPHRI_CMD_START       0
// bits allowed while busy: reset, clear-interrupt, attention request
`define IPHRI_BUSY_OK_MASK    8'h26

// =====================================================================
// reset register values and timing
`define IPHRI_RESET_BYTE      8'h00
`define IPHRI_CONTROLLER_RESET_CMD_TIME_US    100
`define IPHRI_CLK_MHZ         50
`define IPHRI_CONTROLLER_RESET_CMD_CYCLES     (`IPHRI_CONTROLLER_RESET_CMD_TIME_US * `IPHRI_CLK_MHZ)

`endif

// >>> core/iphri_pkg.sv
// types of the host register interface
// assumes iphri_defs.svh for numeric constants
package iphri_pkg;

  // =====================================================================
  // sequencer states
  typedef enum logic [1:0]
  {
    IPHRI_IDLE  = 2'b00,
    IPHRI_FETCH = 2'b01,
    IPHRI_RUN   = 2'b10,
    IPHRI_RESET = 2'b11
  } iphri_seq_t;

endpackage

// >>> core/iphri_addr_gen.sv
// forms the physical parameter block address from relocation and pointer
// assumes all inputs are registered on the same clock
`timescale 1ns/10ps
`default_nettype none

module iphri_addr_gen
(
  // clock
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // inputs
  input  wire logic        ext_mode,
  input  wire logic [15:0] reloc,
  input  wire logic [15:0] pointer,
  // output
  output logic      [23:0] phys_addr
);

  logic [23:0] addr_d;
  logic [23:0] addr_q;

  // =====================================================================
  // address formation
  always_comb
  begin
    if (ext_mode)
      addr_d = {reloc[7:0], pointer};
    else
      addr_d = {4'h0, 20'({reloc, 4'h0} + {4'h0, pointer})};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      addr_q <= 24'h000000;
    else
      addr_q <= addr_d;
  end

  assign phys_addr = addr_q;

endmodule

`default_nettype wire

// >>> core/iphri_regs.sv
// host register interface: pointer, relocation, state and command ports
// assumes a byte port bus on clk_sys and a command engine reporting events
`include "iphri_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module iphri_regs
  import iphri_pkg::*;
#(
  parameter int unsigned CONTROLLER_RESET_CMD_CYCLES = `IPHRI_CONTROLLER_RESET_CMD_CYCLES
)
(
  // clock and resets
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        bus_init,
  // byte port bus
  input  wire logic [7:0]  io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // addressing jumper pin
  input  wire logic        addr_jumper,
  // command engine events
  input  wire logic        eng_fetch_done,
  input  wire logic        eng_chain_end,
  input  wire logic        eng_hard_err,
  input  wire logic        eng_multi_err,
  input  wire logic        eng_status_dma_fail,
  input  wire logic        eng_extra_err,
  input  wire logic        eng_ptr_load,
  input  wire logic [15:0] eng_ptr_value,
  // command engine controls
  output logic             eng_start,
  output logic             eng_fetch_req,
  output logic             eng_abort,
  output logic             eng_attn_hold,
  output logic             eng_byte_mode,
  output logic      [23:0] eng_block_addr,
  output logic             eng_relocate,
  output logic             busy_conflict,
  // interrupt
  output logic             irq
);

  // =====================================================================
  // declarations
  logic [7:0]  reloc_lo_q, reloc_lo_d, reloc_hi_q, reloc_hi_d;
  logic [7:0]  ptr_lo_q, ptr_lo_d, ptr_hi_q, ptr_hi_d;
  logic        err_q, err_d, double_error_flag_q, double_error_flag_d, eff_q, eff_d;
  logic        pend_q, pend_d, ack_q, ack_d, ready_q, ready_d;
  logic        attention_request_q, attention_request_d;
  logic        iaa_q, iaa_d, iec_q, iec_d, bwm_q, bwm_d;
  logic        conflict_q, conflict_d;
  logic        mode_q, mode_d, mode_taken_q;
  logic [2:0]  jmp_sync_q;
  logic [12:0] controller_reset_cmd_cnt_q, controller_reset_cmd_cnt_d;
  iphri_seq_t  seq_q, seq_d;
  logic        wr_state, wr_ptr, cmd_ok, do_start, do_controller_reset_cmd, do_clear_error_cmd, do_clear_interrupt_cmd;
  logic        ack_irq, eoc_irq, do_reset;
  logic [7:0]  rdata_d;
  logic [7:0]  status;

  // =====================================================================
  // parameter check, refused at elaboration
  if (CONTROLLER_RESET_CMD_CYCLES < 1 || CONTROLLER_RESET_CMD_CYCLES > 8191)
  begin : g_controller_reset_cmd_range
    $error("CONTROLLER_RESET_CMD_CYCLES outside counter range");
  end

  // =====================================================================
  // jumper synchroniser, unreset: full of pin level by release, no false early capture
  always_ff @(posedge clk_sys)
  begin
    jmp_sync_q <= {jmp_sync_q[1:0], addr_jumper};
  end

  // =====================================================================
  // write decode
  always_comb
  begin
    wr_state = io_wr && (io_addr == `IPHRI_OFS_STATE_CMD);
    wr_ptr   = io_wr && (io_addr >= `IPHRI_OFS_RELOC_LOW) && (io_addr <= `IPHRI_OFS_PTR_HIGH);
    cmd_ok   = ready_q || ((io_wdata & ~`IPHRI_BUSY_OK_MASK) == 8'h00);
    do_controller_reset_cmd  = wr_state && io_wdata[`IPHRI_CMD_RESET];
    do_clear_interrupt_cmd  = wr_state && io_wdata[`IPHRI_CMD_CLR_IRQ];
    do_clear_error_cmd  = wr_state && ready_q && io_wdata[`IPHRI_CMD_CLR_ERR];
    do_start = wr_state && ready_q && io_wdata[`IPHRI_CMD_START] && !do_controller_reset_cmd;
    do_reset = !nrst || bus_init || do_controller_reset_cmd;
  end

  // =====================================================================
  // register next state
  always_comb
  begin
    reloc_lo_d = reloc_lo_q;
    reloc_hi_d = reloc_hi_q;
    ptr_lo_d   = ptr_lo_q;
    ptr_hi_d   = ptr_hi_q;
    err_d      = err_q;
    double_error_flag_d     = double_error_flag_q;
    eff_d      = eff_q;
    pend_d     = pend_q;
    ack_d      = ack_q;
    ready_d    = ready_q;
    attention_request_d     = attention_request_q;
    iaa_d      = iaa_q;
    iec_d      = iec_q;
    bwm_d      = bwm_q;
    conflict_d = 1'b0;
    ack_irq    = 1'b0;
    eoc_irq    = 1'b0;
    // pointer registers only writable while ready
    if (wr_ptr && ready_q)
    begin
      unique case (io_addr)
        `IPHRI_OFS_RELOC_LOW:  reloc_lo_d = io_wdata;
        `IPHRI_OFS_RELOC_HIGH: reloc_hi_d = io_wdata;
        `IPHRI_OFS_PTR_LOW:    ptr_lo_d   = io_wdata;
        default:               ptr_hi_d   = io_wdata;
      endcase
    end
    if ((wr_ptr && !ready_q) || (wr_state && !cmd_ok))
      conflict_d = 1'b1;
    // clears first, hardware sets afterwards so a coincident event wins
    if (do_clear_error_cmd)
    begin
      err_d  = 1'b0;
      double_error_flag_d = 1'b0;
    end
    if (do_clear_interrupt_cmd)
      pend_d = 1'b0;
    if (wr_state && cmd_ok)
      attention_request_d = io_wdata[`IPHRI_CMD_ATTN_REQ];
    if (do_start)
    begin
      err_d   = 1'b0;
      eff_d   = 1'b0;
      pend_d  = 1'b0;
      ack_d   = 1'b0;
      ready_d = 1'b0;
      iaa_d   = io_wdata[`IPHRI_CMD_IRQ_ACK];
      iec_d   = io_wdata[`IPHRI_CMD_IRQ_EOC];
      bwm_d   = io_wdata[`IPHRI_CMD_BYTE_WORD];
    end
    // attention handshake
    if (attention_request_q && !ack_q && !ready_q && !do_start)
    begin
      ack_d   = 1'b1;
      ack_irq = iaa_q;
    end
    else if (!attention_request_q && ack_q)
      ack_d = 1'b0;
    // engine reports; hard error halts and counts as chain end
    if (eng_hard_err)
    begin
      err_d   = 1'b1;
      ready_d = 1'b1;
      eoc_irq = iec_q;
    end
    else if (eng_chain_end && !ready_q)
    begin
      ready_d = 1'b1;
      eoc_irq = iec_q;
    end
    if (eng_multi_err || eng_status_dma_fail || (eng_hard_err && err_q))
      double_error_flag_d = 1'b1;
    if (eng_extra_err)
      eff_d = 1'b1;
    if (ack_irq || eoc_irq)
      pend_d = 1'b1;
    // engine loads the pointer only on a hard error with eng_ptr_load
    if (eng_hard_err && eng_ptr_load)
      {ptr_hi_d, ptr_lo_d} = eng_ptr_value;
  end

  always_ff @(posedge clk_sys)
  begin
    if (do_reset)
    begin
      reloc_lo_q <= `IPHRI_RESET_BYTE;
      reloc_hi_q <= `IPHRI_RESET_BYTE;
      ptr_lo_q   <= `IPHRI_RESET_BYTE;
      ptr_hi_q   <= `IPHRI_RESET_BYTE;
      err_q      <= 1'b0;
      double_error_flag_q     <= 1'b0;
      eff_q      <= 1'b0;
      pend_q     <= 1'b0;
      ack_q      <= 1'b0;
      ready_q    <= 1'b1;
      attention_request_q     <= 1'b0;
      iaa_q      <= 1'b0;
      iec_q      <= 1'b0;
      bwm_q      <= 1'b0;
      conflict_q <= 1'b0;
    end
    else
    begin
      reloc_lo_q <= reloc_lo_d;
      reloc_hi_q <= reloc_hi_d;
      ptr_lo_q   <= ptr_lo_d;
      ptr_hi_q   <= ptr_hi_d;
      err_q      <= err_d;
      double_error_flag_q     <= double_error_flag_d;
      eff_q      <= eff_d;
      pend_q     <= pend_d;
      ack_q      <= ack_d;
      ready_q    <= ready_d;
      attention_request_q     <= attention_request_d;
      iaa_q      <= iaa_d;
      iec_q      <= iec_d;
      bwm_q      <= bwm_d;
      conflict_q <= conflict_d;
    end
  end

  // =====================================================================
  // addressing mode: taken once after power-up, untouched by software
  always_comb
  begin
    mode_d = mode_q;
    if (!mode_taken_q && (jmp_sync_q[2] == jmp_sync_q[1]))
      mode_d = jmp_sync_q[2];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      mode_q       <= 1'b0;
      mode_taken_q <= 1'b0;
    end
    else
    begin
      mode_q       <= mode_d;
      mode_taken_q <= mode_taken_q || (jmp_sync_q[2] == jmp_sync_q[1]);
    end
  end

  // =====================================================================
  // sequencer: start, fetch, run, and the timed controller reset abort
  always_comb
  begin
    seq_d      = seq_q;
    controller_reset_cmd_cnt_d = controller_reset_cmd_cnt_q;
    unique case (seq_q)
      IPHRI_IDLE:
        if (do_start)
          seq_d = IPHRI_FETCH;
      IPHRI_FETCH:
        if (eng_hard_err)
          seq_d = IPHRI_IDLE;
        else if (eng_fetch_done)
          seq_d = IPHRI_RUN;
      IPHRI_RUN:
        if (eng_hard_err || eng_chain_end)
          seq_d = IPHRI_IDLE;
      IPHRI_RESET:
        if (controller_reset_cmd_cnt_q == 13'h0000)
          seq_d = IPHRI_IDLE;
        else
          controller_reset_cmd_cnt_d = controller_reset_cmd_cnt_q - 13'h0001;
    endcase
    // bounded abort time: engine sees abort for a fixed window
    if (do_controller_reset_cmd)
    begin
      seq_d      = IPHRI_RESET;
      controller_reset_cmd_cnt_d = 13'(CONTROLLER_RESET_CMD_CYCLES - 1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst || bus_init)
    begin
      seq_q      <= IPHRI_IDLE;
      controller_reset_cmd_cnt_q <= 13'h0000;
    end
    else
    begin
      seq_q      <= seq_d;
      controller_reset_cmd_cnt_q <= controller_reset_cmd_cnt_d;
    end
  end

  // =====================================================================
  // read path
  always_comb
  begin
    status = 8'h00;
    status[`IPHRI_ST_HARD_ERR]   = err_q;
    status[`IPHRI_ST_DOUBLE_ERR] = double_error_flag_q;
    status[`IPHRI_ST_ADDR_MODE]  = mode_q;
    status[`IPHRI_ST_IRQ_PEND]   = pend_q;
    status[`IPHRI_ST_ATTN_ACK]   = ack_q;
    status[`IPHRI_ST_READY]      = ready_q;
    unique case (io_addr)
      `IPHRI_OFS_RELOC_LOW:  rdata_d = reloc_lo_q;
      `IPHRI_OFS_RELOC_HIGH: rdata_d = reloc_hi_q;
      `IPHRI_OFS_PTR_LOW:    rdata_d = ptr_lo_q;
      `IPHRI_OFS_PTR_HIGH:   rdata_d = ptr_hi_q;
      `IPHRI_OFS_STATE_CMD:  rdata_d = status;
      default:               rdata_d = 8'h00;
    endcase
    if (!io_rd)
      rdata_d = io_rdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      io_rdata <= 8'h00;
    else
      io_rdata <= rdata_d;
  end

  // =====================================================================
  // address formation
  iphri_addr_gen u_addr
  (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .ext_mode  (mode_q),
    .reloc     ({reloc_hi_q, reloc_lo_q}),
    .pointer   ({ptr_hi_q, ptr_lo_q}),
    .phys_addr (eng_block_addr)
  );

  // =====================================================================
  // outputs to the engine and the bus
  assign eng_start     = (seq_q == IPHRI_IDLE) && (seq_d == IPHRI_FETCH);
  assign eng_fetch_req = (seq_q == IPHRI_FETCH) && !ready_q;
  assign eng_abort     = (seq_q == IPHRI_RESET);
  assign eng_attn_hold = ack_q;
  assign eng_byte_mode = bwm_q;
  assign eng_relocate  = ({reloc_hi_q, reloc_lo_q} != 16'h0000);
  assign busy_conflict = conflict_q;
  assign irq           = pend_q;

endmodule

`default_nettype wire

// >>> tb/iphri_regs_monitor.sv
// port checks of the host register interface
// assumes bound into iphri_regs, one clock domain, defines header on path
`include "iphri_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module iphri_regs_monitor
(
  // clock and resets
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        bus_init,
  // byte port bus
  input wire logic [7:0]  io_addr,
  input wire logic        io_wr,
  input wire logic [7:0]  io_wdata,
  // engine side and interrupt
  input wire logic        eng_start,
  input wire logic        eng_fetch_req,
  input wire logic        eng_abort,
  input wire logic        eng_attn_hold,
  input wire logic [23:0] eng_block_addr,
  input wire logic        eng_relocate,
  input wire logic        busy_conflict,
  input wire logic        irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // =====================================================================
  // checks
  logic cmd_wr;
  assign cmd_wr = io_wr && (io_addr == `IPHRI_OFS_STATE_CMD);

  AST_START_FETCH: assert property (eng_start |=> eng_fetch_req)
    else $error("no fetch request after start");
  AST_BUSY_OK: assert property (cmd_wr && (io_wdata & ~`IPHRI_BUSY_OK_MASK) == 8'h00 |=> !busy_conflict)
    else $error("allowed command flagged as conflict");
  AST_PTR_REFUSED: assert property (eng_start ##2 (io_wr && io_addr inside {8'h82, 8'h83}) |=> busy_conflict)
    else $error("busy pointer write not flagged");
  AST_START_REFUSED: assert property (eng_start ##2 (cmd_wr && io_wdata[0] && !io_wdata[5]) |-> !eng_start)
    else $error("start accepted while busy");
  AST_CLR_IRQ: assert property (cmd_wr && io_wdata[2] |=> !irq)
    else $error("interrupt kept after clear");
  AST_ATTN_SET: assert property (eng_start ##2 (cmd_wr && io_wdata == 8'h02) |-> ##[1:4] eng_attn_hold)
    else $error("attention not acknowledged");
  AST_ATTN_CLR: assert property (eng_attn_hold && cmd_wr && !io_wdata[1] |-> ##[1:4] !eng_attn_hold)
    else $error("acknowledge kept after withdrawal");
  AST_RESET_ABORT: assert property (cmd_wr && io_wdata[5] |-> ##[1:2] (eng_abort && !eng_fetch_req))
    else $error("controller reset did not abort");
  AST_INIT_CLEAR: assert property ($rose(bus_init) |-> ##2 (eng_block_addr == 24'h000000 && !eng_relocate))
    else $error("bus init left address nonzero");

  COV_START: cover property (eng_start);
  COV_CONFLICT: cover property (busy_conflict);
  COV_ACK_IRQ: cover property (eng_attn_hold && irq);
endmodule

bind iphri_regs iphri_regs_monitor mon_u
(
  .clk_sys, .nrst, .bus_init, .io_addr, .io_wr, .io_wdata, .eng_start, .eng_fetch_req,
  .eng_abort, .eng_attn_hold, .eng_block_addr, .eng_relocate, .busy_conflict, .irq
);
`default_nettype wire

// >>> tb/iphri_engine_model.sv
// command engine stand-in: answers fetches, then ends or fails the chain
// assumes the bench sets run length and failure kind before each start
`timescale 1ns/10ps
`default_nettype none

module iphri_engine_model
(
  // clock
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // controls and scenario knobs
  input  wire logic        eng_fetch_req,
  input  wire logic        eng_abort,
  input  wire logic [7:0]  run_len,
  input  wire logic [1:0]  fail_kind,
  input  wire logic [15:0] fail_ptr,
  // events
  output logic             eng_fetch_done,
  output logic             eng_chain_end,
  output logic             eng_hard_err,
  output logic             eng_multi_err,
  output logic             eng_status_dma_fail,
  output logic             eng_extra_err,
  output logic             eng_ptr_load,
  output logic      [15:0] eng_ptr_value
);
  // =====================================================================
  // fetch then run; every event is a one-cycle pulse
  logic [1:0] ph_q;
  logic [7:0] cnt_q;
  assign eng_extra_err = 1'b0;

  always_ff @(posedge clk_sys)
  begin
    {eng_fetch_done, eng_chain_end, eng_hard_err, eng_multi_err, eng_status_dma_fail, eng_ptr_load} <= 6'h00;
    // unqualified value keeps changing, never a stale copy
    eng_ptr_value <= ~eng_ptr_value;
    cnt_q         <= cnt_q - 8'h01;
    if (!nrst || eng_abort)
      ph_q <= 2'h0;
    else if (ph_q == 2'h0 && eng_fetch_req)
    begin
      ph_q  <= 2'h1;
      cnt_q <= 8'h02;
    end
    else if (ph_q == 2'h1 && cnt_q == 8'h00)
    begin
      ph_q           <= 2'h2;
      cnt_q          <= run_len;
      eng_fetch_done <= 1'b1;
    end
    else if (ph_q == 2'h2 && cnt_q == 8'h00)
    begin
      ph_q                <= 2'h0;
      eng_chain_end       <= (fail_kind == 2'h0);
      eng_hard_err        <= (fail_kind != 2'h0);
      eng_ptr_load        <= (fail_kind != 2'h0);
      eng_multi_err       <= (fail_kind == 2'h2);
      eng_status_dma_fail <= (fail_kind == 2'h3);
      eng_ptr_value       <= fail_ptr;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_iphri_regs.sv
// self-checking bench of the host register interface, random register walk
// assumes the engine model on the far side and the bound port monitor
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end

module tb_iphri_regs;
  // =====================================================================
  // wiring
  logic        clk_sys = 1'b0, nrst = 1'b0, bus_init = 1'b0, addr_jumper = 1'b1, jb = 1'b1;
  logic        io_wr = 1'b0, io_rd = 1'b0;
  logic [7:0]  io_addr = 8'h00, io_wdata = 8'h00, io_rdata, run_len = 8'h28;
  logic [1:0]  fail_kind = 2'h0;
  logic [15:0] fail_ptr = 16'h0000, eng_ptr_value;
  logic        eng_fetch_done, eng_chain_end, eng_hard_err, eng_multi_err, eng_status_dma_fail, eng_extra_err;
  logic        eng_ptr_load, eng_start, eng_fetch_req, eng_abort, eng_attn_hold, eng_byte_mode;
  logic        eng_relocate, busy_conflict, irq;
  logic [23:0] eng_block_addr;
  logic [31:0] seed = 32'h0000_9275, wv;
  int          num_errors = 0, comparisons = 0;

  always #10 clk_sys = ~clk_sys;

  iphri_regs #(.CONTROLLER_RESET_CMD_CYCLES(4)) dut_u
  (
    .clk_sys, .nrst, .bus_init, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .addr_jumper,
    .eng_fetch_done, .eng_chain_end, .eng_hard_err, .eng_multi_err, .eng_status_dma_fail, .eng_extra_err,
    .eng_ptr_load, .eng_ptr_value, .eng_start, .eng_fetch_req, .eng_abort, .eng_attn_hold, .eng_byte_mode,
    .eng_block_addr, .eng_relocate, .busy_conflict, .irq
  );
  iphri_engine_model model_u
  (
    .clk_sys, .nrst, .eng_fetch_req, .eng_abort, .run_len, .fail_kind, .fail_ptr, .eng_fetch_done,
    .eng_chain_end, .eng_hard_err, .eng_multi_err, .eng_status_dma_fail, .eng_extra_err, .eng_ptr_load,
    .eng_ptr_value
  );

  // =====================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // flags: error, double, pending, acknowledge, ready
  function automatic logic [7:0] stat(input logic [4:0] f);
    return {f[4], f[3], 2'h0, jb, f[2:0]};
  endfunction
  function automatic logic [23:0] addr_exp(input logic [15:0] r, input logic [15:0] p);
    return jb ? {r[7:0], p} : {4'h0, {r, 4'h0} + {4'h0, p}};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    @(posedge clk_sys);
    d = io_rdata;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK($sformatf("port %h", a), e, d)
  endtask
  task automatic wait_ready();
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 200 && d[0] !== 1'b1; i++)
      rd(8'h84, d);
  endtask
  task automatic wait_ack(input logic v);
    for (int i = 0; i < 8 && eng_attn_hold !== v; i++)
      @(posedge clk_sys);
  endtask
  task automatic power_up(input logic j);
    nrst        <= 1'b0;
    addr_jumper <= j;
    jb = j;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    // captured mode must not follow the pin afterwards
    addr_jumper <= ~j;
  endtask
  task automatic reg_walk();
    for (int k = 0; k < 6; k++)
    begin
      wv = (k == 0) ? 32'h0000_0000 : (k == 1) ? 32'hFFFF_FFFF : rnd();
      for (int i = 0; i < 4; i++)
        wr(8'h80 + 8'(i), wv[8*i +: 8]);
      for (int i = 0; i < 4; i++)
        chk(8'h80 + 8'(i), wv[8*i +: 8]);
      `CHK("block address", addr_exp(wv[15:0], wv[31:16]), eng_block_addr)
      `CHK("relocate", wv[15:0] != 16'h0000, eng_relocate)
    end
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    test_done();
  end

  // =====================================================================
  // scenarios
  initial
  begin
    power_up(1'b1);
    chk(8'h84, stat(5'h01));
    chk(8'h85, 8'h00);
    reg_walk();
    wr(8'h84, 8'h19);
    wr(8'h82, 8'hA5);
    `CHK("byte mode", 1'b1, eng_byte_mode)
    chk(8'h84, stat(5'h00));
    chk(8'h82, wv[23:16]);
    wait_ready();
    `CHK("irq", 1'b1, irq)
    chk(8'h84, stat(5'h05));
    wr(8'h84, 8'h04);
    `CHK("irq", 1'b0, irq)
    wr(8'h84, 8'h00);
    `CHK("byte mode", 1'b1, eng_byte_mode)
    fail_kind <= 2'h1;
    fail_ptr  <= 16'hC3A6;
    wr(8'h84, 8'h11);
    wr(8'h84, 8'h01);
    `CHK("byte mode", 1'b0, eng_byte_mode)
    wait_ready();
    `CHK("irq", 1'b1, irq)
    chk(8'h84, stat(5'h15));
    chk(8'h82, 8'hA6);
    chk(8'h83, 8'hC3);
    for (int k = 2; k < 4; k++)
    begin
      fail_kind <= 2'(k);
      wr(8'h84, 8'h01);
      wait_ready();
      chk(8'h84, stat(5'h19));
      wr(8'h84, 8'h80);
      chk(8'h84, stat(5'h01));
    end
    fail_kind <= 2'h0;
    run_len   <= 8'h78;
    wr(8'h84, 8'h41);
    wr(8'h84, 8'h02);
    wait_ack(1'b1);
    `CHK("acknowledge", 1'b1, eng_attn_hold)
    `CHK("irq", 1'b1, irq)
    chk(8'h84, stat(5'h06));
    wr(8'h84, 8'h00);
    wait_ack(1'b0);
    `CHK("acknowledge", 1'b0, eng_attn_hold)
    wr(8'h84, 8'h04);
    wait_ready();
    `CHK("irq", 1'b0, irq)
    wr(8'h80, 8'h12);
    wr(8'h84, 8'h01);
    wr(8'h84, 8'h20);
    wait_ready();
    chk(8'h80, 8'h00);
    chk(8'h84, stat(5'h01));
    wr(8'h81, 8'h7E);
    bus_init <= 1'b1;
    @(posedge clk_sys);
    bus_init <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(8'h81, 8'h00);
    power_up(1'b0);
    chk(8'h84, stat(5'h01));
    reg_walk();
    test_done();
  end
endmodule
`default_nettype wire
